// ---- design/uart_irq_cfg.svh ----
// Register offsets, field positions, reset values and threshold tables for the FIFO control and interrupt block.
`ifndef UART_IRQ_CFG_SVH
`define UART_IRQ_CFG_SVH

// ------------------------------------------------------------
// Register offsets on the parallel host bus
// ------------------------------------------------------------
`define FIFO_CTRL_ADDR 3'h2
`define IRQ_STATUS_ADDR 3'h2

// ------------------------------------------------------------
// fifo_control field positions
// ------------------------------------------------------------
`define FIFO_CTRL_ENABLE_BIT 0
`define FIFO_CTRL_RX_CLEAR_BIT 1
`define FIFO_CTRL_TX_CLEAR_BIT 2
`define FIFO_CTRL_TX_TRIG_LSB 4
`define FIFO_CTRL_RX_TRIG_LSB 6

// ------------------------------------------------------------
// Enable and feature bits used by the interrupt sources
// ------------------------------------------------------------
`define IRQ_EN_RX_BIT 0
`define IRQ_EN_TX_BIT 1
`define IRQ_EN_LINE_BIT 2
`define IRQ_EN_MODEM_BIT 3
`define IRQ_EN_XOFF_BIT 5
`define IRQ_EN_RTS_BIT 6
`define IRQ_EN_CTS_BIT 7
`define FEATURE_ENHANCED_BIT 4

// ------------------------------------------------------------
// Interrupt codes for status bits 5:0
// ------------------------------------------------------------
`define CODE_LINE 6'h06
`define CODE_RX_READY 6'h04
`define CODE_RX_TIMEOUT 6'h0C
`define CODE_TX_EMPTY 6'h02
`define CODE_MODEM 6'h00
`define CODE_XOFF 6'h10
`define CODE_CTS_RTS 6'h20
`define CODE_NONE 6'h01

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define FIFO_CTRL_RESET 8'h00
`define IRQ_STATUS_RESET 8'h01

// ------------------------------------------------------------
// Trigger levels in 32-byte mode, indexed by the two-bit code
// ------------------------------------------------------------
`define RX_TRIG_0 8'h08
`define RX_TRIG_1 8'h10
`define RX_TRIG_2 8'h18
`define RX_TRIG_3 8'h1C
`define TX_TRIG_0 8'h10
`define TX_TRIG_1 8'h08
`define TX_TRIG_2 8'h18
`define TX_TRIG_3 8'h1E

`endif

// ---- design/uart_irq_pkg.sv ----
// Types shared by the FIFO control and interrupt priority block.
package uart_irq_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [5:0] irq_code_t;
    typedef logic [2:0] reg_addr_t;
    typedef logic [1:0] trig_code_t;
endpackage

// ---- design/trigger_select.sv ----
// Selection of receive and transmit thresholds from the two-bit codes or the level registers.
`timescale 1ns/10ps
`include "uart_irq_cfg.svh"
module trigger_select (
    input wire uart_irq_pkg::trig_code_t rx_code,
    input wire uart_irq_pkg::trig_code_t tx_code,
    input wire uart_irq_pkg::byte_t rx_irq_level_reg,
    input wire uart_irq_pkg::byte_t tx_irq_level_reg,
    input wire uart_irq_pkg::byte_t flow_low_threshold_reg,
    input wire uart_irq_pkg::byte_t flow_high_threshold_reg,
    output uart_irq_pkg::byte_t rx_threshold,
    output uart_irq_pkg::byte_t tx_threshold
);
    import uart_irq_pkg::*;

    logic level_mode;

    // Any nonzero level register hands threshold control over to the level registers.
    assign level_mode = (rx_irq_level_reg != 8'h00) || (tx_irq_level_reg != 8'h00) ||
                        (flow_low_threshold_reg != 8'h00) || (flow_high_threshold_reg != 8'h00);

    always_comb begin
        if (level_mode) begin
            rx_threshold = rx_irq_level_reg;
            tx_threshold = tx_irq_level_reg;
        end else begin
            case (rx_code)
                2'h0: rx_threshold = `RX_TRIG_0;
                2'h1: rx_threshold = `RX_TRIG_1;
                2'h2: rx_threshold = `RX_TRIG_2;
                default: rx_threshold = `RX_TRIG_3;
            endcase
            case (tx_code)
                2'h0: tx_threshold = `TX_TRIG_0;
                2'h1: tx_threshold = `TX_TRIG_1;
                2'h2: tx_threshold = `TX_TRIG_2;
                default: tx_threshold = `TX_TRIG_3;
            endcase
        end
    end
endmodule

// ---- design/irq_priority.sv ----
// Combinational six-level interrupt priority encoder.
`timescale 1ns/10ps
`include "uart_irq_cfg.svh"
module irq_priority (
    input wire logic line_pend,
    input wire logic rx_timeout_pend,
    input wire logic rx_ready_pend,
    input wire logic tx_empty_pend,
    input wire logic modem_pend,
    input wire logic xoff_pend,
    input wire logic cts_rts_pend,
    output uart_irq_pkg::irq_code_t code
);
    import uart_irq_pkg::*;

    // Level 1 is the highest; a time-out outranks plain data ready within level 2.
    always_comb begin
        if (line_pend) begin
            code = `CODE_LINE;
        end else if (rx_timeout_pend) begin
            code = `CODE_RX_TIMEOUT;
        end else if (rx_ready_pend) begin
            code = `CODE_RX_READY;
        end else if (tx_empty_pend) begin
            code = `CODE_TX_EMPTY;
        end else if (modem_pend) begin
            code = `CODE_MODEM;
        end else if (xoff_pend) begin
            code = `CODE_XOFF;
        end else if (cts_rts_pend) begin
            code = `CODE_CTS_RTS;
        end else begin
            code = `CODE_NONE;
        end
    end
endmodule

// ---- design/uart_fifo_ctrl_irq_priority.sv ----
// FIFO control register and prioritised interrupt status for a single-channel UART.
//
// Summary of operation
// - FIFO enable bit turns both FIFOs on or off; off after reset.
// - Transmit clear bit empties the transmit FIFO, then returns to zero itself.
// - Receive clear bit empties the receive FIFO, then returns to zero itself.
// - Receive code picks threshold 8, 16, 24 or 28 bytes.
// - Transmit code picks threshold 16, 8, 24 or 30 bytes.
// - Receive-ready interrupt rises when receive count reaches the threshold.
// - Transmit-empty interrupt rises when transmit count falls below the threshold.
// - The same thresholds also drive flow control.
// - Any nonzero level register makes thresholds come from the level registers.
// - Status read returns the code of the highest pending interrupt.
// - Only the top source is reported; lower ones show on a later read.
// - Line 000110, receive ready 000100, time-out 001100, transmit empty 000010.
// - Modem 000000, Xoff or special 010000, CTS or RTS change 100000.
// - Status bits 7:6 read one with FIFOs enabled, zero otherwise.
// - The two upper sources report only while enhanced feature bit 4 is set.
// - Xoff status stays set until Xon characters arrive.
// - Status bit 0 is low while any interrupt pends; high after reset.
// - Receive-ready clears once the receive count drops below the threshold.
// - Transmit-empty clears on a status read that reports it or a new transmit load.
`timescale 1ns/10ps
`include "uart_irq_cfg.svh"
module uart_fifo_ctrl_irq_priority #(
    parameter int COUNT_W = 8
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire uart_irq_pkg::reg_addr_t addr,
    input wire logic wr_strobe,
    input wire logic rd_strobe,
    input wire uart_irq_pkg::byte_t wdata,
    output uart_irq_pkg::byte_t rdata,
    input wire uart_irq_pkg::byte_t irq_enable_reg,
    input wire uart_irq_pkg::byte_t enhanced_feature_reg,
    input wire uart_irq_pkg::byte_t rx_irq_level_reg,
    input wire uart_irq_pkg::byte_t tx_irq_level_reg,
    input wire uart_irq_pkg::byte_t flow_low_threshold_reg,
    input wire uart_irq_pkg::byte_t flow_high_threshold_reg,
    input wire logic [COUNT_W-1:0] rx_count,
    input wire logic [COUNT_W-1:0] tx_count,
    input wire logic line_status_error,
    input wire logic rx_timeout,
    input wire logic modem_status_change,
    input wire logic xoff_detected,
    input wire logic xon_received,
    input wire logic cts_rts_change,
    input wire logic tx_holding_load,
    output logic fifo_enable,
    output logic rx_fifo_clear,
    output logic tx_fifo_clear,
    output uart_irq_pkg::byte_t rx_threshold,
    output uart_irq_pkg::byte_t tx_threshold,
    output uart_irq_pkg::byte_t interrupt_status,
    output logic irq
);
    import uart_irq_pkg::*;

    // ------------------------------------------------------------
    // Register file state
    // ------------------------------------------------------------
    logic fifo_enable_reg;
    trig_code_t rx_trig_code_reg;
    trig_code_t tx_trig_code_reg;
    logic rx_clear_reg;
    logic tx_clear_reg;
    byte_t rx_threshold_reg;
    byte_t tx_threshold_reg;
    byte_t rdata_reg;
    byte_t status_view_reg;
    logic irq_reg;

    logic ctrl_write;
    logic status_read;
    byte_t rx_thr_sel;
    byte_t tx_thr_sel;

    assign ctrl_write = wr_strobe && (addr == `FIFO_CTRL_ADDR);
    assign status_read = rd_strobe && (addr == `IRQ_STATUS_ADDR);

    // ------------------------------------------------------------
    // FIFO control register
    // ------------------------------------------------------------
    // Only host writes change this state; status reads at the shared address never touch it.
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            fifo_enable_reg <= 1'(`FIFO_CTRL_RESET >> `FIFO_CTRL_ENABLE_BIT);
        end else if (ctrl_write) begin
            fifo_enable_reg <= wdata[`FIFO_CTRL_ENABLE_BIT];
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            rx_trig_code_reg <= 2'(`FIFO_CTRL_RESET >> `FIFO_CTRL_RX_TRIG_LSB);
        end else if (ctrl_write) begin
            rx_trig_code_reg <= wdata[`FIFO_CTRL_RX_TRIG_LSB +: 2];
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            tx_trig_code_reg <= 2'(`FIFO_CTRL_RESET >> `FIFO_CTRL_TX_TRIG_LSB);
        end else if (ctrl_write) begin
            tx_trig_code_reg <= wdata[`FIFO_CTRL_TX_TRIG_LSB +: 2];
        end
    end

    // Clear commands are one-cycle pulses, so the stored bit reads back as zero afterwards.
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            rx_clear_reg <= 1'b0;
        end else begin
            rx_clear_reg <= ctrl_write && wdata[`FIFO_CTRL_RX_CLEAR_BIT];
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            tx_clear_reg <= 1'b0;
        end else begin
            tx_clear_reg <= ctrl_write && wdata[`FIFO_CTRL_TX_CLEAR_BIT];
        end
    end

    // ------------------------------------------------------------
    // Threshold selection
    // ------------------------------------------------------------
    trigger_select thresholds (
        .rx_code(rx_trig_code_reg),
        .tx_code(tx_trig_code_reg),
        .rx_irq_level_reg(rx_irq_level_reg),
        .tx_irq_level_reg(tx_irq_level_reg),
        .flow_low_threshold_reg(flow_low_threshold_reg),
        .flow_high_threshold_reg(flow_high_threshold_reg),
        .rx_threshold(rx_thr_sel),
        .tx_threshold(tx_thr_sel)
    );

    // The registered thresholds feed both the interrupt compare and the flow-control outputs.
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            rx_threshold_reg <= `RX_TRIG_0;
        end else begin
            rx_threshold_reg <= rx_thr_sel;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            tx_threshold_reg <= `TX_TRIG_0;
        end else begin
            tx_threshold_reg <= tx_thr_sel;
        end
    end

    // ------------------------------------------------------------
    // Interrupt sources
    // ------------------------------------------------------------
    logic [7:0] rx_count_w;
    logic [7:0] tx_count_w;
    logic rx_at_level;
    logic tx_below;
    logic tx_below_prev_reg;
    logic tx_empty_flag_reg;
    logic xoff_flag_reg;
    logic cts_rts_flag_reg;
    logic enhanced_on;
    logic line_pend;
    logic rx_timeout_pend;
    logic rx_ready_pend;
    logic tx_empty_pend;
    logic modem_pend;
    logic xoff_pend;
    logic cts_rts_pend;
    irq_code_t top_code;
    logic tx_reported;
    logic cts_rts_reported;

    assign rx_count_w = 8'(rx_count);
    assign tx_count_w = 8'(tx_count);

    // Without FIFOs the single holding register decides: data present, or holding empty.
    assign rx_at_level = fifo_enable_reg ? (rx_count_w >= rx_threshold_reg) : (rx_count_w != 8'h00);
    assign tx_below = fifo_enable_reg ? (tx_count_w < tx_threshold_reg) : (tx_count_w == 8'h00);

    assign enhanced_on = enhanced_feature_reg[`FEATURE_ENHANCED_BIT];

    assign line_pend = irq_enable_reg[`IRQ_EN_LINE_BIT] && line_status_error;
    assign rx_timeout_pend = irq_enable_reg[`IRQ_EN_RX_BIT] && rx_timeout;
    assign rx_ready_pend = irq_enable_reg[`IRQ_EN_RX_BIT] && rx_at_level;
    assign tx_empty_pend = irq_enable_reg[`IRQ_EN_TX_BIT] && tx_empty_flag_reg;
    assign modem_pend = irq_enable_reg[`IRQ_EN_MODEM_BIT] && modem_status_change;
    assign xoff_pend = enhanced_on && irq_enable_reg[`IRQ_EN_XOFF_BIT] && xoff_flag_reg;
    assign cts_rts_pend = enhanced_on && cts_rts_flag_reg;

    irq_priority prio (
        .line_pend(line_pend),
        .rx_timeout_pend(rx_timeout_pend),
        .rx_ready_pend(rx_ready_pend),
        .tx_empty_pend(tx_empty_pend),
        .modem_pend(modem_pend),
        .xoff_pend(xoff_pend),
        .cts_rts_pend(cts_rts_pend),
        .code(top_code)
    );

    // A read only services the source that it actually reported.
    assign tx_reported = status_read && (top_code == `CODE_TX_EMPTY);
    assign cts_rts_reported = status_read && (top_code == `CODE_CTS_RTS);

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            tx_below_prev_reg <= 1'b0;
        end else begin
            tx_below_prev_reg <= tx_below;
        end
    end

    // Transmit empty is an edge into the below-threshold state, held until serviced.
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            tx_empty_flag_reg <= 1'b0;
        end else if (tx_below && !tx_below_prev_reg) begin
            tx_empty_flag_reg <= 1'b1;
        end else if (tx_reported || tx_holding_load) begin
            tx_empty_flag_reg <= 1'b0;
        end
    end

    // Xoff status holds until Xon arrives; a fresh Xoff in the same cycle wins.
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            xoff_flag_reg <= 1'b0;
        end else if (xoff_detected) begin
            xoff_flag_reg <= 1'b1;
        end else if (xon_received) begin
            xoff_flag_reg <= 1'b0;
        end
    end

    // CTS or RTS change is sticky until a status read reports it.
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            cts_rts_flag_reg <= 1'b0;
        end else if (cts_rts_change && (irq_enable_reg[`IRQ_EN_CTS_BIT] || irq_enable_reg[`IRQ_EN_RTS_BIT])) begin
            cts_rts_flag_reg <= 1'b1;
        end else if (cts_rts_reported) begin
            cts_rts_flag_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Status register and read port
    // ------------------------------------------------------------
    byte_t status_now;

    assign status_now = {fifo_enable_reg, fifo_enable_reg, top_code};

    // The read word is captured on the strobe; unmapped reads return zero.
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            rdata_reg <= 8'h00;
        end else if (rd_strobe) begin
            if (status_read) begin
                rdata_reg <= status_now;
            end else begin
                rdata_reg <= 8'h00;
            end
        end
    end

    // Live status view and interrupt line; writes to the status address have no path here.
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            status_view_reg <= `IRQ_STATUS_RESET;
        end else begin
            status_view_reg <= status_now;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= (top_code != `CODE_NONE);
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign rdata = rdata_reg;
    assign fifo_enable = fifo_enable_reg;
    assign rx_fifo_clear = rx_clear_reg;
    assign tx_fifo_clear = tx_clear_reg;
    assign rx_threshold = rx_threshold_reg;
    assign tx_threshold = tx_threshold_reg;
    assign interrupt_status = status_view_reg;
    assign irq = irq_reg;
endmodule

// ---- testbench/uart_irq_checker.sv ----
// Port-level assertions for the FIFO control and interrupt priority block.
`timescale 1ns/10ps
module uart_irq_checker #(
    parameter int COUNT_W = 8
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire uart_irq_pkg::reg_addr_t addr,
    input wire logic wr_strobe,
    input wire logic rd_strobe,
    input wire uart_irq_pkg::byte_t wdata,
    input wire uart_irq_pkg::byte_t irq_enable_reg,
    input wire uart_irq_pkg::byte_t enhanced_feature_reg,
    input wire uart_irq_pkg::byte_t rx_irq_level_reg,
    input wire uart_irq_pkg::byte_t tx_irq_level_reg,
    input wire uart_irq_pkg::byte_t flow_low_threshold_reg,
    input wire uart_irq_pkg::byte_t flow_high_threshold_reg,
    input wire logic [COUNT_W-1:0] rx_count,
    input wire logic line_status_error,
    input wire logic rx_timeout,
    input wire logic fifo_enable,
    input wire logic rx_fifo_clear,
    input wire logic tx_fifo_clear,
    input wire uart_irq_pkg::byte_t rx_threshold,
    input wire uart_irq_pkg::byte_t tx_threshold,
    input wire uart_irq_pkg::byte_t interrupt_status,
    input wire logic irq
);
    import uart_irq_pkg::*;
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    wire logic no_levels;
    wire logic ctrl_wr;
    assign no_levels = ~|{rx_irq_level_reg, tx_irq_level_reg, flow_low_threshold_reg, flow_high_threshold_reg};
    assign ctrl_wr = wr_strobe && (addr == 3'h2);
    function automatic byte_t rx_tab(input trig_code_t c);
        return (c == 2'h0) ? 8'h08 : (c == 2'h1) ? 8'h10 : (c == 2'h2) ? 8'h18 : 8'h1C;
    endfunction
    function automatic byte_t tx_tab(input trig_code_t c);
        return (c == 2'h0) ? 8'h10 : (c == 2'h1) ? 8'h08 : (c == 2'h2) ? 8'h18 : 8'h1E;
    endfunction
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    AST_FIFO_EN: assert property (ctrl_wr |=> fifo_enable == $past(wdata[0]))
        else $error("fifo enable does not follow the written bit");
    AST_TX_CLR: assert property (ctrl_wr && wdata[2] ##1 !wr_strobe |-> tx_fifo_clear ##1 !tx_fifo_clear)
        else $error("transmit clear is not a single pulse");
    AST_RX_CLR: assert property (ctrl_wr && wdata[1] ##1 !wr_strobe |-> rx_fifo_clear ##1 !rx_fifo_clear)
        else $error("receive clear is not a single pulse");
    AST_RX_TRIG: assert property (ctrl_wr ##1 no_levels |=> rx_threshold == rx_tab($past(wdata[7:6], 2)))
        else $error("receive threshold does not match its code");
    AST_TX_TRIG: assert property (ctrl_wr ##1 no_levels |=> tx_threshold == tx_tab($past(wdata[5:4], 2)))
        else $error("transmit threshold does not match its code");
    AST_LEVELS: assert property (!no_levels |=> rx_threshold == $past(rx_irq_level_reg) &&
        tx_threshold == $past(tx_irq_level_reg))
        else $error("thresholds do not follow the level registers");
    AST_LINE_TOP: assert property (line_status_error && irq_enable_reg[2] |=> interrupt_status[5:0] == 6'h06)
        else $error("line status error not reported on top");
    AST_RX_READY: assert property (fifo_enable && irq_enable_reg[0] && rx_count >= rx_threshold &&
        !line_status_error && !rx_timeout |=> interrupt_status[5:0] == 6'h04)
        else $error("receive ready not reported at threshold");
    AST_UPPER_HIDDEN: assert property (!enhanced_feature_reg[4] |=> interrupt_status[5:4] == 2'h0)
        else $error("upper sources reported with the feature bit clear");
    AST_FIFO_BITS: assert property ($stable(fifo_enable) [*3] |-> interrupt_status[7:6] == {2{fifo_enable}})
        else $error("status bits 7:6 do not show the fifo mode");
    AST_PENDING: assert property (interrupt_status[0] == !irq)
        else $error("status bit 0 disagrees with the interrupt line");
    AST_READ_NO_CHANGE: assert property (rd_strobe && !wr_strobe |=> $stable(fifo_enable) &&
        !rx_fifo_clear && !tx_fifo_clear)
        else $error("status read changed the fifo configuration");
endmodule
bind uart_fifo_ctrl_irq_priority uart_irq_checker #(.COUNT_W(COUNT_W)) uart_irq_checker_i (
    .clock(clock), .rst_b(rst_b), .addr(addr), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .wdata(wdata),
    .irq_enable_reg(irq_enable_reg), .enhanced_feature_reg(enhanced_feature_reg),
    .rx_irq_level_reg(rx_irq_level_reg), .tx_irq_level_reg(tx_irq_level_reg),
    .flow_low_threshold_reg(flow_low_threshold_reg), .flow_high_threshold_reg(flow_high_threshold_reg),
    .rx_count(rx_count), .line_status_error(line_status_error), .rx_timeout(rx_timeout),
    .fifo_enable(fifo_enable), .rx_fifo_clear(rx_fifo_clear), .tx_fifo_clear(tx_fifo_clear),
    .rx_threshold(rx_threshold), .tx_threshold(tx_threshold), .interrupt_status(interrupt_status), .irq(irq)
);

// ---- testbench/host_model.sv ----
// Host processor model driving the parallel register interface.
`timescale 1ns/10ps
module host_model (
    input wire logic clock,
    output uart_irq_pkg::reg_addr_t addr,
    output logic wr_strobe,
    output logic rd_strobe,
    output uart_irq_pkg::byte_t wdata,
    input wire uart_irq_pkg::byte_t rdata
);
    import uart_irq_pkg::*;
    initial begin
        addr = 3'h0;
        wr_strobe = 1'b0;
        rd_strobe = 1'b0;
        wdata = 8'h00;
    end
    // Released write data is inverted so a stale value can never look valid.
    task automatic write_reg(input reg_addr_t a, input byte_t v);
        @(posedge clock);
        #1 addr = a;
        wdata = v;
        wr_strobe = 1'b1;
        @(posedge clock);
        #1 wr_strobe = 1'b0;
        wdata = ~v;
    endtask
    // Read data holds until the next strobe, so it is taken one edge late.
    task automatic read_reg(input reg_addr_t a, output byte_t v);
        @(posedge clock);
        #1 addr = a;
        rd_strobe = 1'b1;
        @(posedge clock);
        #1 rd_strobe = 1'b0;
        @(posedge clock);
        #1 v = rdata;
    endtask
endmodule

// ---- testbench/testbench.sv ----
// Self-checking testbench for the FIFO control and interrupt priority block.
`timescale 1ns/10ps
module testbench;
    import uart_irq_pkg::*;
    logic clock, rst_b, wr_strobe, rd_strobe, line, tmo, mdm, fen, rclr, tclr, irq;
    logic [3:0] ev;
    reg_addr_t addr;
    byte_t wdata, rdata, irq_en, feat, rxl, txl, fll, flh, rxc, txc, rxth, txth, stat, d;
    int miscompares, checks_done;
    byte_t rx_exp [4] = '{8'h08, 8'h10, 8'h18, 8'h1C};
    byte_t tx_exp [4] = '{8'h10, 8'h08, 8'h18, 8'h1E};
    byte_t clr_cmd [2] = '{8'h03, 8'h05};
    initial clock = 1'b0;
    always #20 clock = ~clock;
    host_model host_model_i (.clock(clock), .addr(addr), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe),
        .wdata(wdata), .rdata(rdata));
    uart_fifo_ctrl_irq_priority uart_fifo_ctrl_irq_priority_i (
        .clock(clock), .rst_b(rst_b), .addr(addr), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe),
        .wdata(wdata), .rdata(rdata), .irq_enable_reg(irq_en), .enhanced_feature_reg(feat),
        .rx_irq_level_reg(rxl), .tx_irq_level_reg(txl), .flow_low_threshold_reg(fll),
        .flow_high_threshold_reg(flh), .rx_count(rxc), .tx_count(txc), .line_status_error(line),
        .rx_timeout(tmo), .modem_status_change(mdm), .xoff_detected(ev[0]), .xon_received(ev[1]),
        .cts_rts_change(ev[2]), .tx_holding_load(ev[3]), .fifo_enable(fen), .rx_fifo_clear(rclr),
        .tx_fifo_clear(tclr), .rx_threshold(rxth), .tx_threshold(txth), .interrupt_status(stat), .irq(irq)
    );
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic test_done();
        if (miscompares == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input byte_t got, input byte_t exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Three edges let a sticky flag settle before the status is read.
    task automatic rd_chk(input byte_t exp);
        byte_t v;
        repeat (3) @(posedge clock);
        host_model_i.read_reg(3'h2, v);
        chk(v, exp);
    endtask
    task automatic pulse(input logic [3:0] m);
        @(posedge clock);
        #1 ev = m;
        @(posedge clock);
        #1 ev = 4'h0;
    endtask
    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        rst_b = 1'b0;
        {line, tmo, mdm, ev, irq_en, feat, rxl, txl, fll, flh, rxc} = '0;
        txc = 8'h20;
        miscompares = 0;
        checks_done = 0;
        repeat (4) @(posedge clock);
        #1 rst_b = 1'b1;
        chk({7'h0, fen}, 8'h00);
        chk(rxth, 8'h08);
        chk(txth, 8'h10);
        chk(stat, 8'h01);
        rd_chk(8'h01);
        for (int c = 0; c < 4; c++) begin
            host_model_i.write_reg(3'h2, {c[1:0], c[1:0], 4'h1});
            @(posedge clock);
            #1 chk(rxth, rx_exp[c]);
            chk(txth, tx_exp[c]);
            chk({7'h0, fen}, 8'h01);
        end
        foreach (clr_cmd[i]) begin
            host_model_i.write_reg(3'h2, clr_cmd[i]);
            chk({6'h0, tclr, rclr}, {6'h0, clr_cmd[i][2:1]});
            @(posedge clock);
            #1 chk({6'h0, tclr, rclr}, 8'h00);
        end
        host_model_i.write_reg(3'h5, 8'h00);
        host_model_i.read_reg(3'h5, d);
        chk(d, 8'h00);
        chk({7'h0, fen}, 8'h01);
        rxl = 8'h05;
        txl = 8'h03;
        repeat (3) @(posedge clock);
        #1 chk(rxth, 8'h05);
        chk(txth, 8'h03);
        {rxl, txl, fll} = {8'h00, 8'h00, 8'h01};
        repeat (3) @(posedge clock);
        #1 chk(rxth, 8'h00);
        {fll, flh} = {8'h00, 8'h01};
        repeat (3) @(posedge clock);
        #1 chk(txth, 8'h00);
        flh = 8'h00;
        {irq_en, feat, line, tmo, mdm, rxc} = {8'hFF, 8'h10, 3'h7, 8'h08};
        rd_chk(8'hC6);
        chk({7'h0, irq}, 8'h01);
        chk(stat, 8'hC6);
        line = 1'b0;
        rd_chk(8'hCC);
        tmo = 1'b0;
        rd_chk(8'hC4);
        rxc = 8'h07;
        rd_chk(8'hC0);
        mdm = 1'b0;
        pulse(4'h5);
        rd_chk(8'hD0);
        rd_chk(8'hD0);
        feat = 8'h00;
        rd_chk(8'hC1);
        feat = 8'h10;
        rd_chk(8'hD0);
        pulse(4'h2);
        rd_chk(8'hE0);
        rd_chk(8'hC1);
        txc = 8'h0F;
        rd_chk(8'hC2);
        rd_chk(8'hC1);
        txc = 8'h20;
        repeat (2) @(posedge clock);
        #1 txc = 8'h0F;
        repeat (3) @(posedge clock);
        #1 chk({7'h0, irq}, 8'h01);
        pulse(4'h8);
        rd_chk(8'hC1);
        test_done();
    end
    initial begin
        repeat (3000) @(posedge clock);
        miscompares++;
        test_done();
    end
endmodule
